//--- verilog/sev_pkg.sv
//==========================================================
// mode, cause and data event configuration constants
package sev_pkg;

    //==========================================================
    // register offsets
    localparam logic [7:0] ADDR_SYSTEM_MODE      = 8'h11;
    localparam logic [7:0] ADDR_INTERRUPT_CAUSE  = 8'h12;
    localparam logic [7:0] ADDR_DATA_EVENT_CFG   = 8'h13;

    //==========================================================
    // reset values and masks
    localparam logic [7:0] SYSTEM_MODE_RESET     = 8'h00;
    localparam logic [7:0] CAUSE_RESET           = 8'h00;
    localparam logic [7:0] CFG_RESET             = 8'h00;
    localparam logic [7:0] CFG_WRITE_MASK        = 8'h07;
    localparam logic [7:0] UNMAPPED_READ         = 8'h00;

    //==========================================================
    // field positions
    localparam int OP_STATE_BIT                  = 0;
    localparam int NEW_DATA_CAUSE_BIT            = 7;
    localparam int QUEUE_CAUSE_BIT               = 6;
    localparam int PRESSURE_WINDOW_CAUSE_BIT     = 5;
    localparam int TEMPERATURE_WINDOW_CAUSE_BIT  = 4;
    localparam int PRESSURE_THRESHOLD_CAUSE_BIT  = 3;
    localparam int TEMPERATURE_THRESHOLD_CAUSE_BIT = 2;
    localparam int PRESSURE_CHANGE_CAUSE_BIT     = 1;
    localparam int TEMPERATURE_CHANGE_CAUSE_BIT  = 0;
    localparam int EVENT_ON_CHANGE_MODE_BIT      = 2;
    localparam int PRESSURE_EVENT_ENABLE_BIT     = 1;
    localparam int TEMPERATURE_EVENT_ENABLE_BIT  = 0;

    //==========================================================
    // widths and counts
    localparam int PRESSURE_W                    = 16;
    localparam int TEMPERATURE_W                 = 8;
    localparam logic [5:0] QUEUE_FULL_COUNT      = 6'h20;
    localparam logic [5:0] WATERMARK_OFF         = 6'h00;

    //==========================================================
    // carriers
    typedef struct packed {
        logic       rd;
        logic       rd_done;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sev_reg_req_t;

    typedef struct packed {
        logic overwrite;
        logic ready;
        logic block_int_enable;
        logic status_read_done;
        logic data_read_done;
    } sev_data_status_t;

    typedef enum logic [0:0] {
        SEV_DRDY_IDLE,
        SEV_DRDY_STATUS_SEEN
    } sev_drdy_clr_t;

endpackage : sev_pkg

//--- verilog/sev_alerter.sv
`timescale 1ns/1ps
//==========================================================
// window, threshold and change detection for one sample stream
module sev_alerter #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // sample stream and settings
    input  wire logic         sample_valid,
    input  wire logic [W-1:0] sample,
    input  wire logic [W-1:0] target,
    input  wire logic [W-1:0] window,
    // results, one cycle after sample_valid
    output logic              in_window,
    output logic              crossed,
    output logic              changed
);
    import sev_pkg::*;

    logic [W-1:0]        prev;
    logic                have_prev;
    logic signed [W+1:0] v;
    logic signed [W+1:0] pv;
    logic signed [W+1:0] t;
    logic signed [W+1:0] lo;
    logic signed [W+1:0] hi;
    logic                win_on;

    // two guard bits keep target minus window from wrapping
    assign v      = $signed({2'b00, sample});
    assign pv     = $signed({2'b00, prev});
    assign t      = $signed({2'b00, target});
    assign lo     = t - $signed({2'b00, window});
    assign hi     = t + $signed({2'b00, window});
    assign win_on = (window != '0);

    function automatic logic crosses(input logic signed [W+1:0] a,
                                     input logic signed [W+1:0] b,
                                     input logic signed [W+1:0] th);
        crosses = (a < th) != (b < th);
    endfunction : crosses

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev      <= '0;
            have_prev <= 1'b0;
            in_window <= 1'b0;
            crossed   <= 1'b0;
            changed   <= 1'b0;
        end else begin
            crossed <= 1'b0;
            changed <= 1'b0;
            if (sample_valid) begin
                prev      <= sample;
                have_prev <= 1'b1;
                in_window <= win_on && (v >= lo) && (v <= hi); // see RQ7 see RQ8
                crossed   <= have_prev && (crosses(pv, v, t) ||
                             (win_on && (crosses(pv, v, lo) || crosses(pv, v, hi)))); // see RQ9
                changed   <= !have_prev || (sample != prev); // see RQ12
            end
        end
    end

endmodule : sev_alerter

//--- verilog/sev_top.sv
`timescale 1ns/1ps
//==========================================================
// Summary of operation
// RQ1 - bit 0 reports standby 0, active 1
// RQ2 - mode register bits 7 to 1 read zero
// RQ3 - cause bits show raised interrupts, reset zero
// RQ4 - cause bits set on rising edge, clear on read; code clears only bits 5 to 0 on read
// RQ5 - bit 7 new data, cleared status then data
// RQ6 - bit 6 overflow or watermark, cleared by status
// RQ7 - bit 5 pressure inside window, nonzero window
// RQ8 - bit 4 temperature inside window, nonzero window
// RQ9 - bits 3,2 crossing centre, or all three
// RQ10 - bits 1,0 pressure and temperature change
// RQ11 - mode 0 raises event per new sample
// RQ12 - mode 1 raises event only on change; code also raises one on the first sample after reset
// RQ13 - config bit 1 enables pressure data events
// RQ14 - config bit 0 enables temperature data events
// RQ15 - watermark zero disables watermark cause
// RQ16 - count 32 asserts overflow flag
// RQ17 - clear after read completes, set wins
module sev_top (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              sys_rst,
    // register port
    input  wire sev_pkg::sev_reg_req_t             reg_req,
    output logic [7:0]                             reg_rdata,
    // operating state
    input  wire logic                              op_active,
    // data status block
    input  wire sev_pkg::sev_data_status_t         data_status,
    // queue status
    input  wire logic [5:0]                        queue_sample_count,
    input  wire logic [5:0]                        queue_watermark,
    input  wire logic                              queue_status_read_done,
    output logic                                   queue_overflow_flag,
    // pressure stream
    input  wire logic                              pressure_valid,
    input  wire logic [sev_pkg::PRESSURE_W-1:0]    pressure_value,
    input  wire logic [sev_pkg::PRESSURE_W-1:0]    pressure_target,
    input  wire logic [sev_pkg::PRESSURE_W-1:0]    pressure_window,
    // temperature stream
    input  wire logic                              temperature_valid,
    input  wire logic [sev_pkg::TEMPERATURE_W-1:0] temperature_value,
    input  wire logic [sev_pkg::TEMPERATURE_W-1:0] temperature_target,
    input  wire logic [sev_pkg::TEMPERATURE_W-1:0] temperature_window,
    // change detectors
    input  wire logic                              pressure_change,
    input  wire logic                              temperature_change,
    // state and events out
    output logic                                   operating_state_bit,
    output logic [7:0]                             interrupt_cause,
    output logic                                   data_event_flag
);
    import sev_pkg::*;

    //==========================================================
    // decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    //==========================================================
    // alerters
    logic p_within;
    logic p_crossed;
    logic p_changed;
    logic t_within;
    logic t_crossed;
    logic t_changed;

    sev_alerter #(.W(PRESSURE_W)) u_pressure (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sample_valid (pressure_valid),
        .sample       (pressure_value),
        .target       (pressure_target),
        .window       (pressure_window),
        .in_window    (p_within),
        .crossed      (p_crossed),
        .changed      (p_changed)
    );

    sev_alerter #(.W(TEMPERATURE_W)) u_temperature (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sample_valid (temperature_valid),
        .sample       (temperature_value),
        .target       (temperature_target),
        .window       (temperature_window),
        .in_window    (t_within),
        .crossed      (t_crossed),
        .changed      (t_changed)
    );

    //==========================================================
    // cause levels and edges
    logic [7:0]    cause_level;
    logic [7:0]    cause_prev;
    logic [7:0]    cause_set;
    logic [7:0]    cause_clr;
    logic [7:0]    next_cause;
    logic          next_overflow;
    logic          watermark_hit;
    logic          drdy_clear;
    logic [7:0]    data_event_cfg;
    sev_drdy_clr_t drdy_state;

    assign next_overflow = (queue_sample_count == QUEUE_FULL_COUNT); // see RQ16
    assign watermark_hit = (queue_watermark != WATERMARK_OFF) &&
                           (queue_sample_count == queue_watermark); // see RQ15

    always_comb begin
        cause_level = '0;
        cause_level[NEW_DATA_CAUSE_BIT] = (data_status.overwrite || data_status.ready) &&
                                          data_status.block_int_enable; // see RQ5
        cause_level[QUEUE_CAUSE_BIT] = next_overflow || watermark_hit; // see RQ6
        cause_level[PRESSURE_WINDOW_CAUSE_BIT] = p_within; // see RQ7
        cause_level[TEMPERATURE_WINDOW_CAUSE_BIT] = t_within; // see RQ8
        cause_level[PRESSURE_CHANGE_CAUSE_BIT] = pressure_change; // see RQ10
        cause_level[TEMPERATURE_CHANGE_CAUSE_BIT] = temperature_change; // see RQ10
    end

    // crossings are already single-cycle events, so they bypass the edge detector
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_edge
            if (gi == PRESSURE_THRESHOLD_CAUSE_BIT) begin : g_pth
                assign cause_set[gi] = p_crossed; // see RQ9
            end else if (gi == TEMPERATURE_THRESHOLD_CAUSE_BIT) begin : g_tth
                assign cause_set[gi] = t_crossed; // see RQ9
            end else begin : g_rise
                assign cause_set[gi] = cause_level[gi] && !cause_prev[gi]; // see RQ4
            end
        end
    endgenerate

    always_comb begin
        cause_clr = '0;
        if (reg_req.rd_done && hit(reg_req.addr, ADDR_INTERRUPT_CAUSE)) begin
            cause_clr[5:0] = 6'h3F; // see RQ4
        end
        cause_clr[QUEUE_CAUSE_BIT] = queue_status_read_done; // see RQ6
        cause_clr[NEW_DATA_CAUSE_BIT] = drdy_clear; // see RQ5
        // set beats clear in the same cycle
        next_cause = (interrupt_cause & ~cause_clr) | cause_set; // see RQ17
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cause_prev      <= '0;
            interrupt_cause <= CAUSE_RESET; // see RQ3
        end else begin
            cause_prev      <= cause_level;
            interrupt_cause <= next_cause;
        end
    end

    //==========================================================
    // status then data read sequence for the new data cause
    assign drdy_clear = (drdy_state == SEV_DRDY_STATUS_SEEN) && data_status.data_read_done; // see RQ5

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drdy_state <= SEV_DRDY_IDLE;
        end else begin
            case (drdy_state)
                SEV_DRDY_IDLE: begin
                    if (data_status.status_read_done) begin
                        drdy_state <= SEV_DRDY_STATUS_SEEN;
                    end
                end
                SEV_DRDY_STATUS_SEEN: begin
                    if (data_status.data_read_done) begin
                        drdy_state <= SEV_DRDY_IDLE;
                    end
                end
                default: begin
                    drdy_state <= SEV_DRDY_IDLE;
                end
            endcase
        end
    end

    //==========================================================
    // queue overflow and operating state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            queue_overflow_flag <= 1'b0;
            operating_state_bit <= SYSTEM_MODE_RESET[OP_STATE_BIT];
        end else begin
            queue_overflow_flag <= next_overflow; // see RQ16
            operating_state_bit <= op_active; // see RQ1
        end
    end

    //==========================================================
    // data event flag
    logic p_new_d;
    logic t_new_d;
    logic p_event;
    logic t_event;

    // delay the raw valids to line up with the alerter change pulses
    assign p_event = data_event_cfg[EVENT_ON_CHANGE_MODE_BIT] ? p_changed : p_new_d; // see RQ11 see RQ12
    assign t_event = data_event_cfg[EVENT_ON_CHANGE_MODE_BIT] ? t_changed : t_new_d; // see RQ11 see RQ12

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            p_new_d         <= 1'b0;
            t_new_d         <= 1'b0;
            data_event_flag <= 1'b0;
        end else begin
            p_new_d         <= pressure_valid;
            t_new_d         <= temperature_valid;
            data_event_flag <= (data_event_cfg[PRESSURE_EVENT_ENABLE_BIT] && p_event) || // see RQ13
                               (data_event_cfg[TEMPERATURE_EVENT_ENABLE_BIT] && t_event); // see RQ14
        end
    end

    //==========================================================
    // register port
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_event_cfg <= CFG_RESET;
        end else if (reg_req.wr && hit(reg_req.addr, ADDR_DATA_EVENT_CFG)) begin
            data_event_cfg <= reg_req.wdata & CFG_WRITE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= UNMAPPED_READ;
        end else if (reg_req.rd) begin
            if (hit(reg_req.addr, ADDR_SYSTEM_MODE)) begin
                reg_rdata <= {7'h00, operating_state_bit}; // see RQ1 see RQ2
            end else if (hit(reg_req.addr, ADDR_INTERRUPT_CAUSE)) begin
                reg_rdata <= interrupt_cause; // see RQ3
            end else if (hit(reg_req.addr, ADDR_DATA_EVENT_CFG)) begin
                reg_rdata <= data_event_cfg;
            end else begin
                reg_rdata <= UNMAPPED_READ;
            end
        end
    end

endmodule : sev_top

//--- sim/sev_checker.sv
`timescale 1ns/1ps
//==========================================================
// port checker
module sev_checker (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  sys_rst,
    // watched ports
    input wire sev_pkg::sev_reg_req_t reg_req,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  op_active,
    input wire logic [5:0]            queue_sample_count,
    input wire logic                  queue_overflow_flag,
    input wire logic                  pressure_change,
    input wire logic                  temperature_change,
    input wire logic                  temperature_valid,
    input wire logic                  operating_state_bit,
    input wire logic [7:0]            interrupt_cause,
    input wire logic                  data_event_flag
);
    import sev_pkg::*;
    logic [7:0] cfg;
    wire        rd_cause = reg_req.rd_done && reg_req.addr == ADDR_INTERRUPT_CAUSE;
    // shadow of the config register, tracked from writes
    always_ff @(posedge clk) begin
        if (sys_rst) cfg <= 8'h00;
        else if (reg_req.wr && reg_req.addr == ADDR_DATA_EVENT_CFG) cfg <= reg_req.wdata & CFG_WRITE_MASK;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    mode_follow_a: assert property (
        !$past(sys_rst) |-> operating_state_bit == $past(op_active)) else $error("mode bit wrong");
    mode_rsvd_a: assert property (
        reg_req.rd && reg_req.addr == ADDR_SYSTEM_MODE |=> reg_rdata[7:1] == 7'h00) else $error("mode upper bits set");
    cause_reset_a: assert property (disable iff (1'b0)
        sys_rst |=> interrupt_cause == CAUSE_RESET) else $error("cause not reset");
    pchg_rise_a: assert property (
        !$past(sys_rst) && $rose(pressure_change) |=> interrupt_cause[1]) else $error("pressure change lost");
    edge_only_a: assert property (
        $rose(interrupt_cause[1]) && !$past(sys_rst, 2) |-> $past(pressure_change) && !$past(pressure_change, 2))
        else $error("bit set without rise");
    read_clear_a: assert property (
        rd_cause && !pressure_change |=> !interrupt_cause[1]) else $error("bit not cleared by read");
    set_wins_a: assert property (
        rd_cause && $rose(temperature_change) |=> interrupt_cause[0]) else $error("rise lost during read");
    ovf_flag_a: assert property (
        !$past(sys_rst) |-> queue_overflow_flag == ($past(queue_sample_count) == QUEUE_FULL_COUNT))
        else $error("overflow flag wrong");
    no_event_a: assert property (
        (cfg[1:0] == 2'b00) [*3] |-> !data_event_flag) else $error("event while disabled");
    mode0_event_a: assert property (
        (cfg == 8'h01) [*3] ##0 $past(temperature_valid, 2) |-> data_event_flag) else $error("event missing");
    cover property (rd_cause && interrupt_cause != 8'h00);
    cover property (data_event_flag);
    cover property (queue_overflow_flag);
endmodule : sev_checker

bind sev_top sev_checker u_chk (.*);

//--- sim/sev_host.sv
`timescale 1ns/1ps
//==========================================================
// host side register master, one byte per request
module sev_host (
    // clock
    input  wire logic            clk,
    // register port
    output sev_pkg::sev_reg_req_t req,
    input  wire logic [7:0]      rdata
);
    initial req = '0;
    // entered just after an edge; request held for exactly one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge clk);
        #1;
        req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic done, output logic [7:0] d);
        req.rd = 1'b1;
        req.addr = a;
        @(posedge clk);
        #1;
        req.rd = 1'b0;
        d = rdata;
        if (done) begin
            req.rd_done = 1'b1;
            @(posedge clk);
            #1;
            req.rd_done = 1'b0;
        end
    endtask : rd
endmodule : sev_host

//--- sim/tb_top.sv
`timescale 1ns/1ps
//==========================================================
// bench for mode, cause and data event block
module tb_top;
    import sev_pkg::*;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } sev_row_t;
    sev_reg_req_t     reg_req;
    sev_data_status_t data_status;
    sev_row_t         rows[8];
    logic [15:0] pressure_value, pressure_target, pressure_window;
    logic [7:0]  temperature_value, temperature_target, temperature_window, reg_rdata, interrupt_cause, rd_val;
    logic [5:0]  queue_sample_count, queue_watermark;
    logic clk, sys_rst, op_active, queue_status_read_done, queue_overflow_flag, pressure_valid, temperature_valid;
    logic pressure_change, temperature_change, operating_state_bit, data_event_flag;
    int err_total = 0, n_compared = 0, n_ev = 0, n_cyc = 0;

    sev_top u_dut (.*);
    sev_host u_host (.clk(clk), .req(reg_req), .rdata(reg_rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // event counter and hang guard
    always @(posedge clk) begin
        n_cyc <= n_cyc + 1;
        if (data_event_flag === 1'b1) n_ev <= n_ev + 1;
        if (n_cyc == 3000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic smp(input logic [7:0] v, input logic [1:0] m);
        pressure_value = {8'h00, v};
        temperature_value = v;
        {pressure_valid, temperature_valid} = m;
        tick(1);
        {pressure_valid, temperature_valid} = 2'b00;
        tick(4);
    endtask : smp
    task automatic clr;
        u_host.rd(ADDR_INTERRUPT_CAUSE, 1'b1, rd_val);
        tick(1);
    endtask : clr
    task automatic print_verdict;
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    initial begin
        sys_rst = 1'b1;
        {op_active, data_status, queue_status_read_done, pressure_valid, temperature_valid} = '0;
        {pressure_change, temperature_change, queue_sample_count, queue_watermark} = '0;
        {pressure_value, pressure_target, pressure_window} = {16'h0000, 16'h0064, 16'h0000};
        {temperature_value, temperature_target, temperature_window} = {8'h00, 8'h64, 8'h00};
        rows = '{'{1'b0, 8'h11, 8'h00, 8'h00}, '{1'b0, 8'h12, 8'h00, 8'h00}, '{1'b0, 8'h13, 8'h00, 8'h00},
                 '{1'b0, 8'h20, 8'h00, 8'h00}, '{1'b1, 8'h13, 8'hFF, 8'h07}, '{1'b1, 8'h11, 8'hFF, 8'h00},
                 '{1'b1, 8'h12, 8'hFF, 8'h00}, '{1'b1, 8'h13, 8'h00, 8'h00}};
        tick(4);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) u_host.wr(rows[i].addr, rows[i].wdata);
            u_host.rd(rows[i].addr, 1'b0, rd_val);
            chk("reg", rd_val, rows[i].exp);
        end
        op_active = 1'b1;
        tick(2);
        u_host.rd(ADDR_SYSTEM_MODE, 1'b0, rd_val);
        chk("mode", rd_val, 8'h01);
        pressure_change = 1'b1;
        tick(2);
        chk("pchg", interrupt_cause, 8'h02);
        clr;
        tick(2);
        chk("pchg held", interrupt_cause, 8'h00);
        // rise lands on the edge that completes the clearing read
        fork
            clr;
            begin
                tick(1);
                temperature_change = 1'b1;
            end
        join
        tick(1);
        chk("tchg", interrupt_cause, 8'h01);
        data_status.ready = 1'b1;
        tick(3);
        chk("drdy off", interrupt_cause & 8'h80, 8'h00);
        data_status.block_int_enable = 1'b1;
        tick(3);
        chk("drdy", interrupt_cause & 8'h80, 8'h80);
        data_status.data_read_done = 1'b1;
        tick(1);
        data_status.data_read_done = 1'b0;
        data_status.status_read_done = 1'b1;
        tick(1);
        data_status.status_read_done = 1'b0;
        tick(2);
        chk("drdy half", interrupt_cause & 8'h80, 8'h80);
        data_status.data_read_done = 1'b1;
        tick(1);
        data_status.data_read_done = 1'b0;
        tick(2);
        chk("drdy clr", interrupt_cause & 8'h80, 8'h00);
        {queue_watermark, queue_sample_count} = {6'h05, 6'h05};
        tick(3);
        chk("wmrk", interrupt_cause & 8'h40, 8'h40);
        queue_status_read_done = 1'b1;
        tick(1);
        queue_status_read_done = 1'b0;
        queue_sample_count = 6'h00;
        tick(2);
        chk("fifo clr", interrupt_cause & 8'h40, 8'h00);
        queue_sample_count = QUEUE_FULL_COUNT;
        tick(3);
        chk("ovf", {interrupt_cause[6], 6'h00, queue_overflow_flag}, 8'h81);
        clr;
        smp(8'h5A, 2'b11);
        smp(8'h64, 2'b11);
        smp(8'h6E, 2'b11);
        chk("centre", interrupt_cause & 8'h3C, 8'h0C);
        {pressure_window, temperature_window} = {16'h000A, 8'h0A};
        smp(8'h50, 2'b11);
        clr;
        smp(8'h69, 2'b11);
        chk("window", interrupt_cause & 8'h3C, 8'h3C);
        clr;
        smp(8'h73, 2'b11);
        chk("upper", interrupt_cause & 8'h3C, 8'h0C);
        chk("no event", n_ev[7:0], 8'h00);
        u_host.wr(ADDR_DATA_EVENT_CFG, 8'h01);
        smp(8'h73, 2'b01);
        smp(8'h73, 2'b01);
        chk("mode0", n_ev[7:0], 8'h02);
        u_host.wr(ADDR_DATA_EVENT_CFG, 8'h05);
        smp(8'h73, 2'b01);
        smp(8'h78, 2'b01);
        chk("mode1", n_ev[7:0], 8'h03);
        u_host.wr(ADDR_DATA_EVENT_CFG, 8'h02);
        smp(8'h78, 2'b01);
        smp(8'h7D, 2'b10);
        chk("pres only", n_ev[7:0], 8'h04);
        // mid-run reset with causes, overflow and config all non-zero
        sys_rst = 1'b1;
        tick(2);
        chk("rst cause", interrupt_cause, CAUSE_RESET);
        chk("rst outs", {5'h00, data_event_flag, queue_overflow_flag, operating_state_bit}, 8'h00);
        sys_rst = 1'b0;
        u_host.rd(ADDR_DATA_EVENT_CFG, 1'b0, rd_val);
        chk("rst cfg", rd_val, CFG_RESET);
        print_verdict();
    end
endmodule : tb_top
